// File: rtl/ssw_top.v
// mode control and channel routing of the eight-channel low-side switch
`timescale 1ns/10ps
`default_nettype none
`include "ssw_regs.vh"
module ssw_top (
  input wire clk_i,
  input wire nrst_i,
  input wire limp_home_input_i,
  input wire reset_pin_n_i,
  input wire ctrl_pin_1_i,
  input wire ctrl_pin_2_i,
  input wire ctrl_pin_3_i,
  input wire ctrl_pin_4_i,
  input wire sclk_i,
  input wire cs_n_i,
  input wire sdi_i,
  output reg sdo_o,
  output reg [7:0] chan_o,
  output reg irq_o,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o
);
  localparam ST_STANDBY = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_LIMP = 2'd2;

  // pin synchroniser: {cs_n, sclk, sdi, pins 4..1, reset_pin_n, limp}
  wire [8:0] pin_raw;
  wire [8:0] pin_s;
  wire limp_s;
  wire rstpin_n_s;
  wire [3:0] ctrl_s;
  wire sclk_s;
  wire cs_n_s;
  wire sdi_s;

  assign pin_raw = {cs_n_i, sclk_i, sdi_i, ctrl_pin_4_i, ctrl_pin_3_i,
                    ctrl_pin_2_i, ctrl_pin_1_i, reset_pin_n_i,
                    limp_home_input_i};

  // reset values match the idle pin levels (select high, reset pin
  // released) so no false standby entry or frame edge follows reset
  ssw_sync #(
    .W(9),
    .RST_VAL(9'h102)
  ) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i(pin_raw),
    .q_o(pin_s)
  );

  assign limp_s = pin_s[0];
  assign rstpin_n_s = pin_s[1];
  assign ctrl_s = pin_s[5:2];
  assign sdi_s = pin_s[6];
  assign sclk_s = pin_s[7];
  assign cs_n_s = pin_s[8];

  // mode state
  reg [1:0] st_q;
  reg [1:0] st_d;

  always @* begin
    if (limp_s)
      st_d = ST_LIMP;
    else if (!rstpin_n_s)
      st_d = ST_STANDBY;
    else
      st_d = ST_RUN;
  end

  always @(posedge clk_i) begin
    if (!nrst_i)
      st_q <= ST_RUN;
    else
      st_q <= st_d;
  end

  wire in_run;
  wire in_limp;
  wire limp_exit;

  assign in_run = (st_q == ST_RUN);
  assign in_limp = (st_q == ST_LIMP);
  assign limp_exit = in_limp && (st_d != ST_LIMP);

  // serial engine only runs in normal operation
  wire spi_start;
  wire spi_done;
  wire [15:0] spi_rx;
  wire spi_sdo;
  reg [15:0] tx_word;

  ssw_spi u_spi (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(in_run),
    .sclk_i(sclk_s),
    .cs_n_i(cs_n_s),
    .sdi_i(sdi_s),
    .tx_i(tx_word),
    .sdo_o(spi_sdo),
    .start_o(spi_start),
    .done_o(spi_done),
    .rx_o(spi_rx)
  );

  // serial registers
  reg [7:0] on_q;
  reg [7:0] mask_q;
  reg [1:0] sel_q;
  reg [6:0] rd_adr_q;
  reg ter_q;
  wire regs_clr;
  wire spi_wr;
  wire [6:0] spi_adr;

  // anything but normal operation holds the registers at default
  assign regs_clr = !nrst_i || !in_run;
  assign spi_wr = spi_done && spi_rx[`SSW_FR_WRITE_BIT];
  assign spi_adr = spi_rx[`SSW_FR_ADDR_MSB:`SSW_FR_ADDR_LSB];

  always @(posedge clk_i) begin
    if (regs_clr) begin
      on_q <= `SSW_ON_RST;
      mask_q <= `SSW_MASK_RST;
      sel_q <= `SSW_SEL_RST;
      rd_adr_q <= `SSW_SR_ON;
    end else if (spi_done) begin
      rd_adr_q <= spi_adr;
      if (spi_wr && spi_adr == `SSW_SR_ON)
        on_q <= spi_rx[7:0];
      if (spi_wr && spi_adr == `SSW_SR_MASK)
        mask_q <= spi_rx[7:0];
      if (spi_wr && spi_adr == `SSW_SR_SEL)
        sel_q <= spi_rx[1:0];
    end
  end

  // error flag: survives the register clear, reported once
  always @(posedge clk_i) begin
    if (!nrst_i)
      ter_q <= 1'b0;
    else if (limp_exit)
      ter_q <= 1'b1;
    else if (spi_start)
      ter_q <= 1'b0;
  end

  reg [7:0] rd_data;

  always @* begin
    case (rd_adr_q)
      `SSW_SR_ON: rd_data = on_q;
      `SSW_SR_MASK: rd_data = mask_q;
      `SSW_SR_SEL: rd_data = {6'h00, sel_q};
      default: rd_data = 8'h00;
    endcase
    tx_word = {ter_q, 4'h0, rd_adr_q[2:0], rd_data};
  end

  // channel routing
  reg [7:0] chan_d;
  wire [7:0] run_chan;
  wire sel_pin;
  genvar g;

  assign sel_pin = ctrl_s[sel_q];

  // masked channels follow the selected pin, the rest their on bit
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_chan
      assign run_chan[g] = mask_q[g] ? sel_pin : on_q[g];
    end
  endgenerate

  always @* begin
    chan_d = 8'h00;
    case (st_q)
      ST_LIMP: chan_d = {4'h0, ctrl_s};
      ST_RUN: chan_d = run_chan;
      default: chan_d = 8'h00;
    endcase
  end

  // registered outputs keep every mode change glitch-free
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      chan_o <= 8'h00;
      sdo_o <= 1'b0;
    end else begin
      chan_o <= chan_d;
      sdo_o <= spi_sdo;
    end
  end

  // a frame started while in limp is counted as ignored
  reg cs_n_prev_q;

  always @(posedge clk_i) begin
    if (!nrst_i)
      cs_n_prev_q <= 1'b1;
    else
      cs_n_prev_q <= cs_n_s;
  end

  // interrupt status, enable, clear
  reg [`SSW_EV_W-1:0] ev;
  reg [`SSW_EV_W-1:0] irq_stat_q;
  reg [`SSW_EV_W-1:0] irq_en_q;
  wire wb_req;
  wire wb_wr;
  wire [`SSW_EV_W-1:0] clr_mask;

  always @* begin
    ev = {`SSW_EV_W{1'b0}};
    ev[`SSW_EV_LIMP_IN] = !in_limp && (st_d == ST_LIMP);
    ev[`SSW_EV_LIMP_OUT] = limp_exit;
    ev[`SSW_EV_FRAME] = spi_done;
    ev[`SSW_EV_IGNORED] = in_limp && cs_n_prev_q && !cs_n_s;
    ev[`SSW_EV_STANDBY] = (st_q != ST_STANDBY) && (st_d == ST_STANDBY);
  end

  assign wb_req = wb_cyc_i && wb_stb_i;
  // writes land on the edge where the master sees ack
  assign wb_wr = wb_req && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign clr_mask = (wb_wr && wb_adr_i == `SSW_WB_IRQ_CLR) ?
                    wb_dat_i[`SSW_EV_W-1:0] : {`SSW_EV_W{1'b0}};

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      irq_stat_q <= {`SSW_EV_W{1'b0}};
      irq_en_q <= {`SSW_EV_W{1'b0}};
      irq_o <= 1'b0;
    end else begin
      // a new event beats a clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~clr_mask) | ev;
      if (wb_wr && wb_adr_i == `SSW_WB_IRQ_EN)
        irq_en_q <= wb_dat_i[`SSW_EV_W-1:0];
      irq_o <= |(irq_stat_q & irq_en_q);
    end
  end

  // wishbone slave: ack one cycle after the request, dropped after one
  reg [31:0] rd_word;

  always @* begin
    rd_word = 32'h00000000;
    case (wb_adr_i)
      `SSW_WB_STATUS: begin
        rd_word[`SSW_ST_MODE_LSB+1:`SSW_ST_MODE_LSB] = st_q;
        rd_word[`SSW_ST_TER_BIT] = ter_q;
        rd_word[`SSW_ST_LIMP_PIN_BIT] = limp_s;
        rd_word[`SSW_ST_CHAN_LSB+7:`SSW_ST_CHAN_LSB] = chan_o;
      end
      `SSW_WB_IRQ_STAT: rd_word[`SSW_EV_W-1:0] = irq_stat_q;
      `SSW_WB_IRQ_EN: rd_word[`SSW_EV_W-1:0] = irq_en_q;
      `SSW_WB_CHAN_ON: rd_word[7:0] = on_q;
      `SSW_WB_CFG: begin
        rd_word[`SSW_CFG_MASK_LSB+7:`SSW_CFG_MASK_LSB] = mask_q;
        rd_word[`SSW_CFG_SEL_LSB+1:`SSW_CFG_SEL_LSB] = sel_q;
      end
      default: rd_word = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
      if (wb_req && !wb_ack_o && !wb_we_i)
        wb_dat_o <= rd_word;
    end
  end
endmodule
`default_nettype wire

// File: common/ssw_regs.vh
// register offsets, field positions, reset values and frame layout
`ifndef SSW_REGS_VH
`define SSW_REGS_VH

// wishbone register byte offsets
`define SSW_WB_STATUS 8'h00
`define SSW_WB_IRQ_STAT 8'h04
`define SSW_WB_IRQ_CLR 8'h08
`define SSW_WB_IRQ_EN 8'h0C
`define SSW_WB_CHAN_ON 8'h10
`define SSW_WB_CFG 8'h14

// status register fields
`define SSW_ST_MODE_LSB 0
`define SSW_ST_TER_BIT 2
`define SSW_ST_LIMP_PIN_BIT 3
`define SSW_ST_CHAN_LSB 8

// cfg register fields (wishbone view)
`define SSW_CFG_MASK_LSB 0
`define SSW_CFG_SEL_LSB 8

// interrupt event bits
`define SSW_EV_LIMP_IN 0
`define SSW_EV_LIMP_OUT 1
`define SSW_EV_FRAME 2
`define SSW_EV_IGNORED 3
`define SSW_EV_STANDBY 4
`define SSW_EV_W 5

// serial frame layout, msb first
`define SSW_FRAME_BITS 16
`define SSW_FR_WRITE_BIT 15
`define SSW_FR_ADDR_MSB 14
`define SSW_FR_ADDR_LSB 8
`define SSW_FR_TER_BIT 15

// serial register indices
`define SSW_SR_ON 7'h00
`define SSW_SR_MASK 7'h01
`define SSW_SR_SEL 7'h02

// serial register reset values
`define SSW_ON_RST 8'h00
`define SSW_MASK_RST 8'h00
`define SSW_SEL_RST 2'h0

`endif

// File: rtl/ssw_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module ssw_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire clk_i,
  input wire nrst_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_q;

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      meta_q <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: rtl/ssw_spi.v
// serial frame engine, oversampling the link clock on clk_i
`timescale 1ns/10ps
`default_nettype none
`include "ssw_regs.vh"
module ssw_spi (
  input wire clk_i,
  input wire nrst_i,
  input wire en_i,
  input wire sclk_i,
  input wire cs_n_i,
  input wire sdi_i,
  input wire [15:0] tx_i,
  output reg sdo_o,
  output reg start_o,
  output reg done_o,
  output reg [15:0] rx_o
);
  reg sclk_q;
  reg cs_q;
  reg [15:0] sh_q;
  reg [4:0] cnt_q;

  // inputs arrive already synchronised; edges come from one more stage
  always @(posedge clk_i) begin
    if (!nrst_i || !en_i) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      sh_q <= 16'h0000;
      cnt_q <= 5'h00;
      sdo_o <= 1'b0;
      start_o <= 1'b0;
      done_o <= 1'b0;
      rx_o <= 16'h0000;
    end else begin
      start_o <= 1'b0;
      done_o <= 1'b0;
      sclk_q <= sclk_i;
      cs_q <= cs_n_i;
      if (cs_q && !cs_n_i) begin
        sh_q <= tx_i;
        sdo_o <= tx_i[15];
        cnt_q <= 5'h00;
        start_o <= 1'b1;
      end else if (!cs_n_i) begin
        if (!sclk_q && sclk_i) begin
          sh_q <= {sh_q[14:0], sdi_i};
          if (cnt_q != `SSW_FRAME_BITS)
            cnt_q <= cnt_q + 5'h01;
        end
        if (sclk_q && !sclk_i)
          sdo_o <= sh_q[15];
      end else if (!cs_q && cs_n_i) begin
        // a frame shorter than 16 bits is dropped silently; a longer one keeps its last 16 bits
        if (cnt_q == `SSW_FRAME_BITS) begin
          rx_o <= sh_q;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/ssw_top_assertions.sv
// port-level assertions for the switch mode block
`timescale 1ns/10ps
`default_nettype none
module ssw_top_assertions (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic limp_home_input_i,
  input wire logic reset_pin_n_i,
  input wire logic ctrl_pin_1_i,
  input wire logic ctrl_pin_2_i,
  input wire logic ctrl_pin_3_i,
  input wire logic ctrl_pin_4_i,
  input wire logic sdo_o,
  input wire logic [7:0] chan_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  logic [3:0] lh_q, rp_q, pk_q;
  wire logic [3:0] pins = {ctrl_pin_4_i, ctrl_pin_3_i, ctrl_pin_2_i,
    ctrl_pin_1_i};
  function automatic logic [3:0] inc(input logic [3:0] n);
    return n + {3'h0, n != 4'hF};
  endfunction
  // settle counters: pins cross two sync stages plus mode and output regs
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      lh_q <= 4'h0;
      rp_q <= 4'h0;
      pk_q <= 4'h0;
    end else begin
      lh_q <= limp_home_input_i ? inc(lh_q) : 4'h0;
      rp_q <= (limp_home_input_i | reset_pin_n_i) ? 4'h0 : inc(rp_q);
      pk_q <= $stable(pins) ? inc(pk_q) : 4'h0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_reset_clear: assert property ($rose(nrst_i) |->
    chan_o == 8'h00 && !sdo_o && !wb_ack_o) else $error("reset outputs");
  a_limp_upper: assert property (lh_q > 4'h6 |->
    chan_o[7:4] == 4'h0) else $error("upper channels on in limp");
  a_limp_route: assert property (lh_q > 4'h6 && pk_q > 4'h6 |->
    chan_o[3:0] == pins) else $error("limp routing");
  a_limp_wins: assert property (lh_q > 4'h6 && pk_q > 4'h6 &&
    !reset_pin_n_i |-> chan_o[3:0] == pins) else $error("limp over reset");
  a_limp_quiet: assert property (lh_q > 4'h6 |-> !sdo_o)
    else $error("serial out active in limp");
  a_standby_off: assert property (rp_q > 4'h6 |->
    chan_o == 8'h00) else $error("channel on in standby");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o) else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
endmodule
bind ssw_top ssw_top_assertions i_ssw_top_assertions (.*);
`default_nettype wire

// File: dv/ssw_host.sv
// host side serial master model
`timescale 1ns/10ps
`default_nettype none
module ssw_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  // idle like the pin pulls: clock low, select high, data low
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // mode 0, msb first; clock stands still between frames
  task automatic xfer(input logic [15:0] d, output logic [15:0] r);
    // step off the block's sampling edge before touching the pins
    #1;
    cs_n_o = 1'b0;
    #37;
    for (int i = 15; i >= 0; i--) begin
      sdi_o = d[i];
      #32;
      sclk_o = 1'b1;
      r[i] = sdo_i;
      #32;
      sclk_o = 1'b0;
    end
    #32;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    // long gap so the register write lands before the next frame
    #64;
  endtask
endmodule
`default_nettype wire

// File: dv/ssw_top_tb.sv
// self-checking bench for the switch mode block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n,e,a) begin samples_checked++; if ((a)!==(e)) begin \
 n_mismatch++; $display("CHECK FAILED %s exp %h got %h",n,e,a); end end
module ssw_top_tb;
  logic clk_i=0, nrst_i=0, limp_home_input_i=0, reset_pin_n_i=1;
  logic ctrl_pin_1_i=0, ctrl_pin_2_i=0, ctrl_pin_3_i=0, ctrl_pin_4_i=0;
  logic wb_cyc_i=0, wb_stb_i=0, wb_we_i=0;
  logic [3:0] wb_sel_i=4'hF, p;
  logic [7:0] wb_adr_i=8'h00, chan_o, v, m, c;
  logic [31:0] wb_dat_i=32'h0, wb_dat_o;
  logic [15:0] r, x;
  logic [63:0] q[$], e;
  logic sclk_i, cs_n_i, sdi_i, sdo_o, irq_o, wb_ack_o;
  int n_mismatch=0, samples_checked=0;
  initial forever #2 clk_i = ~clk_i;
  ssw_top i_ssw_top (.*);
  ssw_host i_ssw_host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdi_o(sdi_i),
    .sdo_i(sdo_o));
  task close_out;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // reads note {mask, expected}; the watcher compares at the ack edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, k);
    int t;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    if (!w)
      q.push_back({k, d & k});
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 40);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (t >= 40) begin
      n_mismatch++;
      close_out();
    end
  endtask
  always @(posedge clk_i)
    if (wb_ack_o && !wb_we_i && q.size() > 0) begin
      e = q.pop_front();
      `CHK("wb_read", e[31:0], wb_dat_o & e[63:32])
    end
  task spi(input logic [15:0] d, input logic [15:0] y);
    i_ssw_host.xfer(d, r);
    `CHK("spi_resp", y, r)
  endtask
  task w8;
    repeat (8) @(posedge clk_i);
  endtask
  task pins(input logic [3:0] n);
    @(posedge clk_i);
    {ctrl_pin_4_i, ctrl_pin_3_i, ctrl_pin_2_i, ctrl_pin_1_i} <= n;
  endtask
  initial begin
    v = 8'($urandom(36617));
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    `CHK("chan_rst", 8'h00, chan_o)
    wb(0, 8'h00, 32'h1, 32'hFFFFFFFF);
    wb(0, 8'hFC, 32'h0, 32'hFFFFFFFF);
    spi({8'h80, v}, 16'h0000);
    w8;
    `CHK("chan_on", v, chan_o)
    m = 8'($urandom) | 8'h11;
    spi({8'h81, m}, {8'h00, v});
    x = {8'h01, m};
    for (int s = 0; s < 8; s++) begin
      spi({8'h82, 6'h0, s[1:0]}, x);
      x = {8'h02, 6'h0, s[1:0]};
      p = 4'($urandom);
      pins(p);
      w8;
      c = (v & ~m) | (m & {8{p[s[1:0]]}});
      `CHK("chan_in", c, chan_o)
    end
    wb(1, 8'h08, 32'h1F, 32'h0);
    wb(1, 8'h0C, 32'h4, 32'h0);
    wb(0, 8'h04, 32'h0, 32'h1F);
    wb(0, 8'h08, 32'h0, 32'hFFFFFFFF);
    spi(16'h0000, x);
    w8;
    `CHK("irq_on", 1'b1, irq_o)
    wb(0, 8'h04, 32'h4, 32'h4);
    wb(1, 8'h0C, 32'h0, 32'h0);
    w8;
    `CHK("irq_mask", 1'b0, irq_o)
    wb(1, 8'h0C, 32'h4, 32'h0);
    wb(1, 8'h08, 32'h4, 32'h0);
    w8;
    `CHK("irq_clr", 1'b0, irq_o)
    @(posedge clk_i);
    reset_pin_n_i <= 1'b0;
    w8;
    `CHK("chan_stby", 8'h00, chan_o)
    wb(0, 8'h00, 32'h0, 32'h3);
    p = 4'($urandom);
    pins(p);
    limp_home_input_i <= 1'b1;
    w8;
    `CHK("chan_limp", {4'h0, p}, chan_o)
    wb(0, 8'h00, {20'h0, p, 8'h0A}, 32'hFF0B);
    wb(0, 8'h14, 32'h0, 32'h3FF);
    spi(16'h80FF, 16'h0000);
    w8;
    `CHK("chan_limp", {4'h0, p}, chan_o)
    @(posedge clk_i);
    limp_home_input_i <= 1'b0;
    w8;
    `CHK("chan_out", 8'h00, chan_o)
    wb(0, 8'h00, 32'h0, 32'h3);
    wb(0, 8'h04, 32'h1B, 32'h1F);
    @(posedge clk_i);
    reset_pin_n_i <= 1'b1;
    w8;
    wb(0, 8'h00, 32'h5, 32'h7);
    spi(16'h0000, 16'h8000);
    spi(16'h0000, 16'h0000);
    close_out();
  end
  initial begin
    #200000;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
